// *** inc/ecppe_pkg.sv ***
// Package for the ECP parallel port engine: map, modes, states, pin bundles
package ecppe_pkg;

  // Host I/O map, byte offsets within the port window
  localparam logic [10:0] ECPPE_ADDR_DATA  = 11'h000;  // Data register / address_rle_fifo_port
  localparam logic [10:0] ECPPE_ADDR_DSR   = 11'h001;  // Status register
  localparam logic [10:0] ECPPE_ADDR_DCR   = 11'h002;  // Control register
  localparam logic [10:0] ECPPE_ADDR_FIFO  = 11'h400;  // ecp_data_fifo_port / test_fifo_port
  localparam logic [10:0] ECPPE_ADDR_CNFGB = 11'h401;  // Configuration B in mode 111
  localparam logic [10:0] ECPPE_ADDR_ECR   = 11'h402;  // Extended control register

  // Mode field encodings (extended control bits 7..5)
  localparam logic [2:0] ECPPE_MODE_SPP  = 3'h0;  // Standard, FIFO held in reset
  localparam logic [2:0] ECPPE_MODE_PS2  = 3'h1;  // Bidirectional, direction writable
  localparam logic [2:0] ECPPE_MODE_PFIFO = 3'h2; // Standard-protocol FIFO
  localparam logic [2:0] ECPPE_MODE_ECP  = 3'h3;  // ECP protocol
  localparam logic [2:0] ECPPE_MODE_TEST = 3'h6;  // Test FIFO, no port traffic
  localparam logic [2:0] ECPPE_MODE_CFG  = 3'h7;  // Configuration registers

  // Field positions inside the extended control register
  localparam int ECPPE_ECR_MODE_LSB = 5;
  localparam int ECPPE_ECR_NERR     = 4;
  localparam int ECPPE_ECR_DMA_ENABLE_BIT    = 3;
  localparam int ECPPE_ECR_SVC      = 2;

  // Field positions inside the control register
  localparam int ECPPE_DCR_DIR    = 5;
  localparam int ECPPE_DCR_ACKIE  = 4;
  localparam int ECPPE_DCR_SELIN  = 3;
  localparam int ECPPE_DCR_INIT   = 2;
  localparam int ECPPE_DCR_AFD    = 1;
  localparam int ECPPE_DCR_STB    = 0;

  // Fixed read values and reset values
  localparam logic [7:0] ECPPE_CNFGA_VAL  = 8'h10;  // 8-bit implementation
  localparam logic [2:0] ECPPE_CNFGB_IRQ  = 3'h0;   // IRQ routed elsewhere
  localparam logic [7:0] ECPPE_DCR_RST    = 8'h00;
  localparam logic [2:0] ECPPE_MODE_RST   = 3'h0;
  localparam int         ECPPE_FIFO_DEPTH = 16;

  // Handshake sequencer, Gray along the forward path; the reverse step RREL to IDLE changes two bits
  typedef enum logic [2:0] {
    ECPPE_IDLE = 3'b000,  // Nothing in flight
    ECPPE_FSET = 3'b001,  // Byte on PD, strobe still high
    ECPPE_FSTB = 3'b011,  // Strobe low, wait for Busy high
    ECPPE_FREL = 3'b010,  // Strobe high, wait for Busy low
    ECPPE_RREQ = 3'b100,  // HostAck asserted, wait for nAck low
    ECPPE_RREL = 3'b101   // Byte taken, wait for nAck high
  } ecppe_state_e;

  // Pins driven toward the peripheral
  typedef struct packed {
    logic [7:0] pd;          // Data lines
    logic       pd_oe;       // High while the host drives PD
    logic       nstrobe;     // HostClk
    logic       nautofd;     // HostAck
    logic       ninit;       // nReverseRequest
    logic       nselectin;   // ECPMode
  } ecppe_pout_s;

  // Pins sampled from the peripheral
  typedef struct packed {
    logic [7:0] pd;          // Data lines as seen on the wire
    logic       busy;        // PeriphAck
    logic       nack;        // PeriphClk
    logic       perror;      // nAckReverse
    logic       select;      // Xflag
    logic       nfault;      // nPeriphRequest
  } ecppe_pin_s;

  // Floppy controller drive-side signals, active high inside the chip
  typedef struct packed {
    logic drive_a_motor;
    logic drive_a_select;
    logic drive_b_motor;
    logic drive_b_select;
  } ecppe_fdrv_s;

  // Floppy controller sense inputs, as the drive presents them
  typedef struct packed {
    logic disk_change_input;
    logic read_data;
    logic write_protect;
    logic track_zero_input;
    logic index;
  } ecppe_fsense_s;

endpackage

// *** logic/ecppe_fifo.sv ***
// Shared byte FIFO behind every FIFO view of the port
`timescale 1ns/10ps
`default_nettype none
module ecppe_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = ecppe_pkg::ECPPE_FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             core_ce,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] rdata,
  output logic      [AW:0]      count,
  output logic                  full,
  output logic                  empty
);
  import ecppe_pkg::*;

  // Pointer state kept together
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } ecppe_fptr_s;

  logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset needed
  ecppe_fptr_s      s_q;          // Registered pointers
  ecppe_fptr_s      s_d;          // Next pointers
  logic             do_push;      // Push that really lands
  logic             do_pop;       // Pop that really leaves

  // Overflow and underflow are dropped rather than corrupting pointers
  assign do_push = push & ~full & ~flush;
  assign do_pop  = pop & ~empty & ~flush;
  assign rdata   = mem[s_q.rp];
  assign count   = s_q.cnt;
  assign full    = (s_q.cnt == (AW+1)'(DEPTH));
  assign empty   = (s_q.cnt == '0);

  // Next pointer values
  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d = '0;
    end else begin
      if (do_push) s_d.wp = s_q.wp + 1'b1;
      if (do_pop) s_d.rp = s_q.rp + 1'b1;
      if (do_push && !do_pop) s_d.cnt = s_q.cnt + 1'b1;
      else if (do_pop && !do_push) s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  // Pointer registers, frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) s_q <= '0;
    else if (core_ce) s_q <= s_d;
  end

  // Storage write
  always_ff @(posedge core_clk) begin
    if (core_ce && do_push) mem[s_q.wp] <= wdata;
  end

endmodule
`default_nettype wire

// *** logic/ecppe_floppy.sv ***
// Floppy extension pin forcing and sense-input merging
`timescale 1ns/10ps
`default_nettype none
module ecppe_floppy (
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    core_ce,
  input  wire logic                    single_floppy_extension_mode,
  input  wire logic                    dual_floppy_extension_mode,
  input  wire logic [4:0]              pd_in,
  input  wire ecppe_pkg::ecppe_fdrv_s  drv_in,
  input  wire ecppe_pkg::ecppe_fsense_s sense_in,
  output ecppe_pkg::ecppe_fdrv_s       drv_out,
  output ecppe_pkg::ecppe_fsense_s     sense_out
);
  import ecppe_pkg::*;

  // All state of this module
  typedef struct packed {
    ecppe_fdrv_s   drv;
    ecppe_fsense_s sense;
  } ecppe_flop_s;

  ecppe_flop_s s_q;  // Registered pins
  ecppe_flop_s s_d;  // Next values
  logic        ext;  // Either extension mode active

  assign ext       = single_floppy_extension_mode | dual_floppy_extension_mode;
  assign drv_out   = s_q.drv;
  assign sense_out = s_q.sense;

  // Forcing and merging
  always_comb begin
    s_d       = '0;
    s_d.drv   = drv_in;
    s_d.sense = sense_in;
    // Drive B is lost to the connector in both modes
    if (ext) begin
      s_d.drv.drive_b_motor  = 1'b0;
      s_d.drv.drive_b_select = 1'b0;
    end
    // Dual mode also takes over drive A
    if (dual_floppy_extension_mode) begin
      s_d.drv.drive_a_motor  = 1'b0;
      s_d.drv.drive_a_select = 1'b0;
    end
    // External drive senses arrive on PD4..PD0
    if (ext) begin
      s_d.sense = sense_in | ecppe_fsense_s'(pd_in);
    end
  end

  // Output registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) s_q <= '0;
    else if (core_ce) s_q <= s_d;
  end

endmodule
`default_nettype wire

// *** logic/ecppe_top.sv ***
// ECP parallel port engine: registers, FIFO handshakes, DMA and service requests
`timescale 1ns/10ps
`default_nettype none
module ecppe_top #(
  parameter int FIFO_DEPTH = ecppe_pkg::ECPPE_FIFO_DEPTH,
  parameter int THR_W      = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     core_ce,
  input  wire logic [10:0]              io_addr,
  input  wire logic [7:0]               io_wdata,
  input  wire logic                     io_wr,
  input  wire logic                     io_rd,
  output logic      [7:0]               io_rdata,
  input  wire logic                     dma_ack,
  input  wire logic                     dma_tc,
  output logic                          port_dma_request,
  output logic                          irq,
  input  wire logic [THR_W-1:0]         fifo_threshold,
  input  wire ecppe_pkg::ecppe_pin_s    pin_in,
  output ecppe_pkg::ecppe_pout_s        pin_out,
  input  wire logic                     single_floppy_extension_mode,
  input  wire logic                     dual_floppy_extension_mode,
  input  wire ecppe_pkg::ecppe_fdrv_s   fdrv_in,
  input  wire ecppe_pkg::ecppe_fsense_s fsense_in,
  output ecppe_pkg::ecppe_fdrv_s        fdrv_out,
  output ecppe_pkg::ecppe_fsense_s      fsense_out
);
  import ecppe_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);

  // Whole state of the engine
  typedef struct packed {
    ecppe_state_e st;        // Handshake sequencer
    logic [2:0]   mode;      // Extended control mode field
    logic         nerr_dis;  // Error interrupt disable
    logic         dma_enable_bit;     // dma_enable_bit
    logic         svc;       // service_interrupt_bit
    logic [7:0]   dcr;       // Control register
    logic [7:0]   data;      // Data register for programmed modes
    logic         nfault_p;  // Previous nFault, for edge detect
    ecppe_pout_s  pout;      // Registered pin drive
    logic [7:0]   rdata;     // Registered read answer
    logic         drq;       // Registered DMA request
    logic         irq;       // Registered interrupt pulse
  } ecppe_state_s;

  ecppe_state_s     s_q;        // Current state
  ecppe_state_s     s_d;        // Next state
  logic [8:0]       f_wdata;    // FIFO entry: command tag and byte
  logic [8:0]       f_rdata;    // FIFO head
  logic [AW:0]      f_count;    // Entries held
  logic             f_full;     // No free entry
  logic             f_empty;    // No entry
  logic             f_push;     // Entry written this cycle
  logic             f_pop;      // Entry removed this cycle
  logic             f_flush;    // Modes 000 and 001 keep the FIFO cleared
  logic             wr_any;     // Host or DMA write
  logic             rd_any;     // Host or DMA read
  logic             fifo_wr;    // Write aimed at a FIFO view
  logic             fifo_rd;    // Read aimed at a FIFO view
  logic             dir;        // Current direction bit
  logic             auto_mode;  // Hardware handshake active
  logic [AW:0]      free_cnt;   // Free entries

  // True for modes that use the FIFO from the system side
  function automatic logic fifo_mode(input logic [2:0] m);
    fifo_mode = (m == ECPPE_MODE_PFIFO) || (m == ECPPE_MODE_ECP) || (m == ECPPE_MODE_TEST);
  endfunction

  // True when a write or read hits a given register
  function automatic logic hit(input logic [10:0] a, input logic [10:0] reg_off);
    hit = (a == reg_off);
  endfunction

  assign dir       = s_q.dcr[ECPPE_DCR_DIR];
  assign auto_mode = (s_q.mode == ECPPE_MODE_ECP) || (s_q.mode == ECPPE_MODE_PFIFO);
  assign wr_any    = io_wr & core_ce;
  assign rd_any    = io_rd & core_ce;
  // DMA cycles land in the data or test FIFO view in modes 010, 011 and 110 only
  assign fifo_wr = wr_any & fifo_mode(s_q.mode) & (dma_ack | hit(io_addr, ECPPE_ADDR_FIFO)
                   | (hit(io_addr, ECPPE_ADDR_DATA) & (s_q.mode == ECPPE_MODE_ECP)));
  assign fifo_rd = rd_any & fifo_mode(s_q.mode) & (dma_ack | hit(io_addr, ECPPE_ADDR_FIFO))
                   & (dir | (s_q.mode == ECPPE_MODE_TEST));
  assign f_flush  = (s_q.mode == ECPPE_MODE_SPP) || (s_q.mode == ECPPE_MODE_PS2);
  assign free_cnt = (AW+1)'(FIFO_DEPTH) - f_count;

  // Push source: reverse capture, else host/DMA write with command tag
  always_comb begin
    f_push  = 1'b0;
    f_wdata = '0;
    if (s_q.st == ECPPE_RREQ && !pin_in.nack && core_ce) begin
      f_push  = 1'b1;
      f_wdata = {~pin_in.busy, pin_in.pd};
    end else if (fifo_wr && (!dir || s_q.mode == ECPPE_MODE_TEST)) begin
      f_push  = 1'b1;
      // Address port entries are tagged as commands
      f_wdata = {(!dma_ack && hit(io_addr, ECPPE_ADDR_DATA)), io_wdata};
    end
  end

  // Pop source: forward sequencer or host/DMA read
  assign f_pop = core_ce & ((s_q.st == ECPPE_IDLE && auto_mode && !dir && !f_empty
                 && !pin_in.busy) | fifo_rd);

  // Single shared store for every FIFO view
  ecppe_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (AW)
  ) u_fifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .core_ce  (core_ce),
    .flush    (f_flush),
    .push     (f_push),
    .wdata    (f_wdata),
    .pop      (f_pop),
    .rdata    (f_rdata),
    .count    (f_count),
    .full     (f_full),
    .empty    (f_empty)
  );

  // Floppy extension pin handling
  ecppe_floppy u_floppy (
    .core_clk                     (core_clk),
    .resetn                       (resetn),
    .core_ce                      (core_ce),
    .single_floppy_extension_mode (single_floppy_extension_mode),
    .dual_floppy_extension_mode   (dual_floppy_extension_mode),
    .pd_in                        (pin_in.pd[4:0]),
    .drv_in                       (fdrv_in),
    .sense_in                     (fsense_in),
    .drv_out                      (fdrv_out),
    .sense_out                    (fsense_out)
  );

  // Next-state logic: registers, sequencer, DMA and interrupts
  always_comb begin
    logic svc_set;
    logic [2:0] nm;
    svc_set = 1'b0;
    nm      = io_wdata[7:ECPPE_ECR_MODE_LSB];
    s_d     = s_q;
    s_d.irq = 1'b0;
    s_d.nfault_p = pin_in.nfault;

    // Register writes from the host
    if (wr_any && !dma_ack) begin
      if (hit(io_addr, ECPPE_ADDR_ECR)) begin
        // Mode moves only out of, or back into, the programmed modes
        if (s_q.mode == ECPPE_MODE_SPP || s_q.mode == ECPPE_MODE_PS2
            || nm == ECPPE_MODE_SPP || nm == ECPPE_MODE_PS2) begin
          s_d.mode = nm;
        end
        s_d.nerr_dis = io_wdata[ECPPE_ECR_NERR];
        s_d.dma_enable_bit    = io_wdata[ECPPE_ECR_DMA_ENABLE_BIT];
        s_d.svc      = io_wdata[ECPPE_ECR_SVC];
      end else if (hit(io_addr, ECPPE_ADDR_DCR)) begin
        s_d.dcr = io_wdata;
        // Direction is frozen outside the bidirectional mode
        if (s_q.mode != ECPPE_MODE_PS2) s_d.dcr[ECPPE_DCR_DIR] = dir;
      end else if (hit(io_addr, ECPPE_ADDR_DATA) && s_q.mode != ECPPE_MODE_ECP) begin
        s_d.data = io_wdata;
      end
    end

    // Read answers, registered one cycle after the strobe
    if (rd_any) begin
      if (fifo_rd) s_d.rdata = f_rdata[7:0];
      else if (hit(io_addr, ECPPE_ADDR_DATA))
        s_d.rdata = (s_q.mode == ECPPE_MODE_PS2 && dir) ? pin_in.pd : s_q.data;
      else if (hit(io_addr, ECPPE_ADDR_DSR))
        s_d.rdata = {~pin_in.busy, pin_in.nack, pin_in.perror, pin_in.select,
                     pin_in.nfault, 3'h7};
      else if (hit(io_addr, ECPPE_ADDR_DCR)) s_d.rdata = {2'h3, s_q.dcr[5:0]};
      else if (hit(io_addr, ECPPE_ADDR_ECR))
        s_d.rdata = {s_q.mode, s_q.nerr_dis, s_q.dma_enable_bit, s_q.svc, f_full, f_empty};
      else if (hit(io_addr, ECPPE_ADDR_FIFO) && s_q.mode == ECPPE_MODE_CFG)
        s_d.rdata = ECPPE_CNFGA_VAL;
      else if (hit(io_addr, ECPPE_ADDR_CNFGB) && s_q.mode == ECPPE_MODE_CFG)
        s_d.rdata = {1'b0, s_q.irq, ECPPE_CNFGB_IRQ, 3'h7};
      else s_d.rdata = 8'h00;
    end

    // Handshake sequencer
    case (s_q.st)
      ECPPE_IDLE: begin
        if (f_pop && !fifo_rd) begin
          s_d.pout.pd = f_rdata[7:0];
          // Commands go out with HostAck low
          s_d.pout.nautofd = (s_q.mode == ECPPE_MODE_ECP) ? ~f_rdata[8] : 1'b1;
          s_d.st = ECPPE_FSET;
        end else if (s_q.mode == ECPPE_MODE_ECP && dir && !pin_in.perror && !f_full) begin
          s_d.pout.nautofd = 1'b0;
          s_d.st = ECPPE_RREQ;
        end
      end
      ECPPE_FSET: begin
        s_d.pout.nstrobe = 1'b0;
        s_d.st = ECPPE_FSTB;
      end
      ECPPE_FSTB: begin
        // Peripheral takes the byte and raises Busy
        if (pin_in.busy) begin
          s_d.pout.nstrobe = 1'b1;
          s_d.st = ECPPE_FREL;
        end
      end
      ECPPE_FREL: begin
        // Busy low means room for the next byte
        if (!pin_in.busy) s_d.st = ECPPE_IDLE;
      end
      ECPPE_RREQ: begin
        if (!pin_in.nack) begin
          s_d.pout.nautofd = 1'b1;
          s_d.st = ECPPE_RREL;
        end
      end
      ECPPE_RREL: begin
        if (pin_in.nack) s_d.st = ECPPE_IDLE;
      end
      default: s_d.st = ECPPE_IDLE;
    endcase

    // Leaving the automatic modes abandons any handshake in flight
    if (!auto_mode) s_d.st = ECPPE_IDLE;

    // Programmed-mode pins follow the control register, PD follows the data register
    if (!auto_mode || s_d.st == ECPPE_IDLE) begin
      s_d.pout.nstrobe = auto_mode ? 1'b1 : ~s_q.dcr[ECPPE_DCR_STB];
      if (!auto_mode) s_d.pout.nautofd = ~s_q.dcr[ECPPE_DCR_AFD];
      if (!auto_mode) s_d.pout.pd = s_q.data;
    end
    // Reverse request follows direction while in ECP mode
    s_d.pout.ninit = (s_q.mode == ECPPE_MODE_ECP) ? ~dir : s_q.dcr[ECPPE_DCR_INIT];
    s_d.pout.nselectin = (s_q.mode == ECPPE_MODE_ECP) ? 1'b1
                         : ~s_q.dcr[ECPPE_DCR_SELIN];
    // Drive PD only forward, and in ECP only once nAckReverse says forward
    s_d.pout.pd_oe = !dir && (s_q.mode != ECPPE_MODE_ECP || pin_in.perror)
                     && s_q.mode != ECPPE_MODE_TEST;

    // Service events, only while no prior service is pending; terminal count when DMA is enabled, else threshold
    if (!s_q.svc) begin
      if (s_q.dma_enable_bit) svc_set = dma_ack && dma_tc && core_ce;
      else if (fifo_mode(s_q.mode) && !f_flush)
        svc_set = dir ? (f_count >= (AW+1)'(fifo_threshold))
                      : (free_cnt >= (AW+1)'(fifo_threshold));
    end
    // Hardware set wins over a software clear in the same cycle
    if (svc_set) begin
      s_d.svc = 1'b1;
      s_d.irq = 1'b1;
    end

    // Error interrupt on the falling edge of nFault, forward ECP only
    if (s_q.mode == ECPPE_MODE_ECP && !dir && !s_q.nerr_dis
        && s_q.nfault_p && !pin_in.nfault) begin
      s_d.irq = 1'b1;
    end

    // DMA request: needs enable, no service pending, room or data
    s_d.drq = s_q.dma_enable_bit && !s_d.svc && fifo_mode(s_q.mode)
              && (dir ? !f_empty : !f_full) && !(dma_ack && dma_tc);
  end

  // State register; reset leaves mode 000, so the FIFO stays cleared
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q              <= '0;
      s_q.st           <= ECPPE_IDLE;
      s_q.mode         <= ECPPE_MODE_RST;
      s_q.dcr          <= ECPPE_DCR_RST;
      s_q.nfault_p     <= 1'b1;
      s_q.pout.nstrobe <= 1'b1;
      s_q.pout.nautofd <= 1'b1;
      s_q.pout.nselectin <= 1'b1;
      s_q.pout.pd_oe   <= 1'b1;
    end else if (core_ce) begin
      s_q <= s_d;
    end
  end

  assign io_rdata         = s_q.rdata;
  assign port_dma_request = s_q.drq;
  assign irq              = s_q.irq;
  assign pin_out          = s_q.pout;

endmodule
`default_nettype wire

// *** tb/ecppe_periph.sv ***
// Behavioural ECP peripheral facing the port engine pins
`timescale 1ns/10ps
`default_nettype none
module ecppe_periph (
  input  wire ecppe_pkg::ecppe_pout_s po,
  input  wire logic                  core_clk,
  input  wire logic [8:0]            rev_word,
  input  wire logic [3:0]            lag,
  input  wire logic                  nflt,
  output ecppe_pkg::ecppe_pin_s      pi,
  output logic [8:0]                 got,
  output logic                       got_v
);
  import ecppe_pkg::*;
  logic [7:0] pd_q = 8'h00;  // Peripheral side of PD
  logic [3:0] cnt = 4'h0;    // Cycles before Busy answers
  logic       busy_q = 1'b0;
  logic       nack_q = 1'b1;
  logic       perr_q = 1'b1;
  // Wire level: host wins only while its enable is high
  assign pi = {po.pd_oe ? po.pd : pd_q, busy_q, nack_q, perr_q, 1'b1, nflt};
  // Handshakes; a released PD shows the inverse of the last byte
  always @(posedge core_clk) begin
    got_v <= 1'b0;
    perr_q <= po.ninit;
    if (!perr_q) begin
      if (!po.nautofd && nack_q) begin
        {busy_q, pd_q, nack_q} <= {rev_word, 1'b0};
      end else if (po.nautofd && !nack_q) begin
        {pd_q, nack_q} <= {~pd_q, 1'b1};
      end
    end else if (!po.nstrobe && !busy_q) begin
      cnt <= (cnt >= lag) ? 4'h0 : cnt + 4'h1;
      if (cnt >= lag) begin
        {busy_q, got, got_v} <= {1'b1, po.nautofd, po.pd, 1'b1};
      end
    end else if (po.nstrobe) begin
      busy_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/ecppe_top_assertions.sv ***
// Pin, DMA and floppy checks on the port engine; assumes core_ce high
`timescale 1ns/10ps
`default_nettype none
module ecppe_top_assertions (
  input wire logic                     core_clk,
  input wire logic                     resetn,
  input wire logic                     dma_ack,
  input wire logic                     dma_tc,
  input wire logic                     port_dma_request,
  input wire logic                     irq,
  input wire ecppe_pkg::ecppe_pin_s    pin_in,
  input wire ecppe_pkg::ecppe_pout_s   pin_out,
  input wire logic                     single_floppy_extension_mode,
  input wire logic                     dual_floppy_extension_mode,
  input wire ecppe_pkg::ecppe_fsense_s fsense_in,
  input wire ecppe_pkg::ecppe_fdrv_s   fdrv_out,
  input wire ecppe_pkg::ecppe_fsense_s fsense_out
);
  import ecppe_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic tc = dma_ack && dma_tc && port_dma_request;  // Terminal count taken
  wire logic ext = single_floppy_extension_mode || dual_floppy_extension_mode;
  property p_stb_hold; !pin_out.nstrobe && !pin_in.busy |=> !pin_out.nstrobe; endproperty
  property p_stb_rel; !pin_out.nstrobe && pin_in.busy |=> pin_out.nstrobe; endproperty
  property p_pd_hold; !pin_out.nstrobe |-> $stable(pin_out.pd); endproperty
  property p_tc_drq; tc |-> ##[1:2] !port_dma_request; endproperty
  property p_tc_irq; tc |-> ##[1:2] irq; endproperty
  property p_irq_pulse; irq |=> !irq; endproperty
  property p_dual; dual_floppy_extension_mode |=> fdrv_out == 4'h0; endproperty
  property p_single;
    single_floppy_extension_mode |=> !fdrv_out.drive_b_motor && !fdrv_out.drive_b_select;
  endproperty
  property p_or; ext |=> fsense_out == ($past(fsense_in) | $past(pin_in.pd[4:0])); endproperty
  a_stb_hold: assert property (p_stb_hold) else $error("strobe released early");
  a_stb_rel: assert property (p_stb_rel) else $error("strobe held past busy");
  a_pd_hold: assert property (p_pd_hold) else $error("data moved under strobe");
  a_tc_drq: assert property (p_tc_drq) else $error("request after count");
  a_tc_irq: assert property (p_tc_irq) else $error("no interrupt at count");
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
  a_dual: assert property (p_dual) else $error("drive outputs not forced");
  a_single: assert property (p_single) else $error("drive b not forced");
  a_or: assert property (p_or) else $error("sense merge wrong");
  c_fwd: cover property ($fell(pin_out.nstrobe));
  c_tc: cover property (tc);
  c_rev: cover property ($fell(pin_out.nautofd) && !pin_in.perror);
endmodule
bind ecppe_top ecppe_top_assertions u_chk (.core_clk, .resetn, .dma_ack, .dma_tc,
  .port_dma_request, .irq, .pin_in, .pin_out, .single_floppy_extension_mode,
  .dual_floppy_extension_mode, .fsense_in, .fdrv_out, .fsense_out);
`default_nettype wire

// *** tb/testbench.sv ***
// Directed bench for the ECP port engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ecppe_pkg::*;
  logic          core_clk = 1'b0;
  logic          resetn = 1'b0;
  logic [10:0]   io_addr = 11'h000;
  logic [7:0]    io_wdata = 8'h00, io_rdata;
  logic          io_wr = 1'b0, io_rd = 1'b0, dma_ack = 1'b0, dma_tc = 1'b0, drq, irq;
  logic          sfm = 1'b0, dfm = 1'b0, nflt = 1'b1, got_v;
  logic [8:0]    got, rev_word = 9'h15a;  // Reverse bytes are plain data
  logic [3:0]    lag = 4'h0;              // Peripheral answer delay
  ecppe_pin_s    pin_in;
  ecppe_pout_s   pin_out;
  ecppe_fdrv_s   fdrv_in = 4'hf, fdrv_out;
  ecppe_fsense_s fsense_in = 5'h00, fsense_out;
  int            n_fail = 0, comparisons = 0, n_irq = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (irq === 1'b1) n_irq <= n_irq + 1;
  ecppe_top u_dut (.core_clk, .resetn, .core_ce(1'b1), .io_addr, .io_wdata, .io_wr, .io_rd,
    .io_rdata, .dma_ack, .dma_tc, .port_dma_request(drq), .irq, .fifo_threshold(4'h4),
    .pin_in, .pin_out, .single_floppy_extension_mode(sfm), .dual_floppy_extension_mode(dfm),
    .fdrv_in, .fsense_in, .fdrv_out, .fsense_out);
  ecppe_periph u_per (.po(pin_out), .core_clk, .rev_word, .lag, .nflt, .pi(pin_in), .got, .got_v);
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One-cycle write; dma raises acknowledge and terminal count together
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic dma = 1'b0);
    @(posedge core_clk);
    {io_addr, io_wdata, io_wr, dma_ack, dma_tc} <= {a, d, 1'b1, dma, dma};
    @(posedge core_clk);
    {io_wr, dma_ack, dma_tc} <= 3'b000;
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge core_clk);
    {io_addr, io_rd} <= {a, 1'b1};
    @(posedge core_clk);
    io_rd <= 1'b0;
    @(negedge core_clk);
    chk({2'b00, io_rdata}, {2'b00, e});
  endtask
  // Bounded wait for the peripheral to latch one byte
  task automatic take(input logic [8:0] e);
    for (int i = 0; i < 300 && got_v !== 1'b1; i++) @(negedge core_clk);
    chk({got_v, got}, {1'b1, e});
    @(negedge core_clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    wr(ECPPE_ADDR_DCR, 8'h2c);  // Direction bit is ignored in mode 000
    rd(ECPPE_ADDR_ECR, 8'h01);
    chk(10'(pin_out.nselectin), 10'h0);
    wr(ECPPE_ADDR_ECR, 8'h64);
    rd(ECPPE_ADDR_ECR, 8'h65);
    chk(10'(pin_out.ninit), 10'h1);
    chk(10'(pin_out.nselectin), 10'h1);
    wr(ECPPE_ADDR_ECR, 8'hc4);
    rd(ECPPE_ADDR_ECR, 8'h65);
    lag <= 4'h6;  // Slow answers, so no byte passes before take looks
    wr(ECPPE_ADDR_DATA, 8'h85);
    wr(ECPPE_ADDR_FIFO, 8'h3c);
    wr(ECPPE_ADDR_FIFO, 8'ha5);
    take(9'h085);
    take(9'h13c);
    take(9'h1a5);
    wr(ECPPE_ADDR_ECR, 8'h24);
    rd(ECPPE_ADDR_ECR, 8'h25);
    wr(ECPPE_ADDR_DCR, 8'h20);
    wr(ECPPE_ADDR_ECR, 8'h64);
    repeat (200) @(negedge core_clk);
    chk(10'(pin_out.pd_oe), 10'h0);
    rd(ECPPE_ADDR_ECR, 8'h66);
    rd(ECPPE_ADDR_FIFO, 8'h5a);
    wr(ECPPE_ADDR_ECR, 8'h04);  // Mode 000 flushes what is left
    wr(ECPPE_ADDR_ECR, 8'h24);
    wr(ECPPE_ADDR_DCR, 8'h04);
    wr(ECPPE_ADDR_ECR, 8'h68);
    repeat (3) @(negedge core_clk);
    chk(10'(drq), 10'h1);
    wr(ECPPE_ADDR_FIFO, 8'h77, 1'b1);
    take(9'h177);
    chk(10'(drq), 10'h0);
    rd(ECPPE_ADDR_ECR, 8'h6d);
    wr(ECPPE_ADDR_ECR, 8'h60);
    rd(ECPPE_ADDR_ECR, 8'h65);
    @(posedge core_clk) nflt <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk(10'(n_irq), 10'h3);
    @(posedge core_clk);
    {sfm, fsense_in} <= {1'b1, 5'h08};
    repeat (2) @(negedge core_clk);
    chk(10'(fdrv_out), 10'h00c);
    chk(10'(fsense_out), 10'h01f);
    @(posedge core_clk);
    {sfm, dfm} <= 2'b01;
    repeat (2) @(negedge core_clk);
    chk(10'(fdrv_out), 10'h000);
    wr(ECPPE_ADDR_ECR, 8'h04);
    wr(ECPPE_ADDR_ECR, 8'h44);
    wr(ECPPE_ADDR_FIFO, 8'hc3);
    take(9'h1c3);
    wr(ECPPE_ADDR_ECR, 8'h04);
    wr(ECPPE_ADDR_ECR, 8'he4);
    rd(ECPPE_ADDR_ECR, 8'he5);
    tally_and_finish;
  end
endmodule
`default_nettype wire
